// ==== logic/rsc_defs.vh ====
/*
 * Constants for the reset and strap capture block: timing, strap
 * encodings and reset values.
 * Assumes the includer sets the timescale and net type itself.
 */
`ifndef RSC_DEFS_VH
`define RSC_DEFS_VH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define RSC_CLK_PERIOD_PS   100000
`define RSC_STRAP_DELAY_PS  1500000
`define RSC_STRAP_DELAY_CYC ((`RSC_STRAP_DELAY_PS + `RSC_CLK_PERIOD_PS - 1) / `RSC_CLK_PERIOD_PS)
`define RSC_CNT_W           5

// ----------------------------------------------------------------
// Strap encodings
// ----------------------------------------------------------------
`define RSC_HOST_SPI        1'h0
`define RSC_HOST_I2C        1'h1
`define RSC_SPI_MODE_0_3    1'h0
`define RSC_SPI_MODE_1_2    1'h1
`define RSC_CODE_CRC8       1'h0
`define RSC_CODE_CHKSUM8    1'h1
`define RSC_PARK_ACTIVE     1'h0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RSC_LOW_RST         1'h0
`define RSC_OE_OFF          1'h0
`define RSC_CFG_RST         1'h0
`define RSC_CFG_SET         1'h1
`define RSC_PARK_RST        1'h1

`endif

// ==== logic/rsc_top.v ====
/*
 * Reset and strap capture: holds pads safe while the power-on reset
 * is low, waits about 1.5 us after release, latches the three strap
 * pins once, publishes the host port configuration and passes the
 * park request on.
 * Assumes arst_n_in is the board power-on reset, held low by the
 * supervisor until supplies and clocks are stable, and that all pad
 * inputs are synchronous to ref_clk_in.
 */
`timescale 1ns/1ps
`default_nettype none
`include "rsc_defs.vh"

//Contract
// - Low reset holds; rising edge starts configuration.
// - Seven safe signals driven low in reset.
// - All other outputs tristated during reset; mirror_park_out is driven high instead.
// - Straps sampled about 1.5 us after release.
// - Host strap 0 selects SPI, 1 I2C.
// - Unselected host port becomes diagnostic monitor port.
// - SPI mode strap 0 modes 0/3, 1 modes 1/2.
// - Integrity strap 0 CRC8, 1 checksum8, command only.
// - Park input low parks mirrors, high runs.
// - Strap pins never driven before sampling completes.
module rsc_top
#(
	parameter GP_W      = 8,
	parameter DELAY_CYC = `RSC_STRAP_DELAY_CYC
)
(
	input  wire            ref_clk_in,
	input  wire            arst_n_in,
	// Strap pads
	input  wire            host_if_strap_in,
	output wire            host_if_strap_out,
	output wire            host_if_strap_oe_out,
	input  wire            spi_mode_strap_in,
	output wire            spi_mode_strap_out,
	output wire            spi_mode_strap_oe_out,
	input  wire            integrity_code_select_in,
	output wire            integrity_code_select_out,
	output wire            integrity_code_select_oe_out,
	// Debug drive of strap pads, honoured only after sampling
	input  wire [2:0]      dbg_strap_oe_in,
	input  wire [2:0]      dbg_strap_val_in,
	// Park request
	input  wire            mirror_park_n_in,
	output wire            mirror_park_out,
	// Core values for the seven pads held low in reset
	input  wire [3:0]      core_illum_sel_in,
	input  wire            core_mirror_rst_n_in,
	input  wire            core_adc_clk_in,
	input  wire            core_adc_sdo_in,
	output wire            illum_source_sel_0_out,
	output wire            illum_source_sel_1_out,
	output wire            illum_source_sel_2_out,
	output wire            illum_source_sel_3_out,
	output wire            mirror_array_reset_n_out,
	output wire            monitor_adc_clk_out,
	output wire            monitor_adc_sdo_out,
	// Other device pads, tristated in reset
	input  wire [GP_W-1:0] core_gp_val_in,
	input  wire [GP_W-1:0] core_gp_oe_in,
	output wire [GP_W-1:0] gp_pad_out,
	output wire [GP_W-1:0] gp_pad_oe_out,
	// Configuration results
	output wire            init_start_out,
	output wire            config_valid_out,
	output wire            spi_cmd_en_out,
	output wire            i2c_cmd_en_out,
	output wire            spi_diag_en_out,
	output wire            i2c_diag_en_out,
	output wire            spi_mode_1_2_out,
	output wire            cmd_use_checksum_out
);

	// ------------------------------------------------------------
	// Sequencer states
	// ------------------------------------------------------------
	localparam [1:0] ST_START = 2'h0;
	localparam [1:0] ST_WAIT  = 2'h1;
	localparam [1:0] ST_DONE  = 2'h2;

	// The delay count is cut to the counter width on purpose; keep
	// DELAY_CYC within 1..32 or the capture point wraps.
	localparam integer          LAST_INT = DELAY_CYC - 1;
	localparam [`RSC_CNT_W-1:0] LAST_CNT = LAST_INT[`RSC_CNT_W-1:0];
	localparam [`RSC_CNT_W-1:0] CNT_ZERO = {`RSC_CNT_W{1'h0}};
	localparam [`RSC_CNT_W-1:0] CNT_STEP = {{(`RSC_CNT_W-1){1'h0}}, 1'h1};

	reg [1:0]            state_q;
	reg [1:0]            state_d;
	reg [`RSC_CNT_W-1:0] cnt_q;
	reg [`RSC_CNT_W-1:0] cnt_d;
	reg                  init_start_q;
	reg                  cfg_valid_q;
	reg                  spi_mode_q;
	reg                  code_sel_q;
	reg                  spi_cmd_q;
	reg                  i2c_cmd_q;
	reg                  spi_diag_q;
	reg                  i2c_diag_q;
	reg                  park_q;
	reg [2:0]            strap_oe_q;
	reg [2:0]            strap_val_q;
	reg [3:0]            illum_q;
	reg                  mrst_n_q;
	reg                  adc_clk_q;
	reg                  adc_sdo_q;
	reg [GP_W-1:0]       gp_val_q;
	reg [GP_W-1:0]       gp_oe_q;

	wire                 sample_now;

	// ------------------------------------------------------------
	// Release sequence
	// ------------------------------------------------------------
	// The first cycle after release starts configuration; the delay
	// counter then runs so straps settle through their weak pulls.
	assign sample_now = (state_q == ST_WAIT) && (cnt_q == LAST_CNT);

	always @*
	begin
		state_d = state_q;
		cnt_d   = cnt_q;
		case (state_q)
			ST_START:
			begin
				state_d = ST_WAIT;
				cnt_d   = CNT_ZERO;
			end
			ST_WAIT:
			begin
				if (sample_now)
					state_d = ST_DONE;
				else
					cnt_d = cnt_q + CNT_STEP;
			end
			ST_DONE:
			begin
				state_d = ST_DONE;
			end
			default:
			begin
				state_d = ST_START;
				cnt_d   = CNT_ZERO;
			end
		endcase
	end

	always @(posedge ref_clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			state_q <= ST_START;
			cnt_q   <= CNT_ZERO;
		end
		else
		begin
			state_q <= state_d;
			cnt_q   <= cnt_d;
		end
	end

	// One-cycle start pulse for the core, raised by the reset release
	always @(posedge ref_clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			init_start_q <= `RSC_CFG_RST;
		else
			init_start_q <= (state_q == ST_START);
	end

	// ------------------------------------------------------------
	// Strap capture and host port configuration
	// ------------------------------------------------------------
	// Captured once per release; later pad activity, including our
	// own debug drive, never reaches these flops.
	always @(posedge ref_clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			spi_mode_q  <= `RSC_CFG_RST;
			code_sel_q  <= `RSC_CFG_RST;
			spi_cmd_q   <= `RSC_CFG_RST;
			i2c_cmd_q   <= `RSC_CFG_RST;
			spi_diag_q  <= `RSC_CFG_RST;
			i2c_diag_q  <= `RSC_CFG_RST;
		end
		else if (sample_now)
		begin
			spi_mode_q  <= (spi_mode_strap_in == `RSC_SPI_MODE_1_2);
			code_sel_q  <= (integrity_code_select_in == `RSC_CODE_CHKSUM8);
			spi_cmd_q   <= (host_if_strap_in == `RSC_HOST_SPI);
			i2c_cmd_q   <= (host_if_strap_in == `RSC_HOST_I2C);
			spi_diag_q  <= (host_if_strap_in == `RSC_HOST_I2C);
			i2c_diag_q  <= (host_if_strap_in == `RSC_HOST_SPI);
		end
	end

	// Valid flag sticks until the next reset; nothing else clears it
	always @(posedge ref_clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			cfg_valid_q <= `RSC_CFG_RST;
		else if (sample_now)
			cfg_valid_q <= `RSC_CFG_SET;
	end

	// ------------------------------------------------------------
	// Pad control
	// ------------------------------------------------------------
	// Safe pads stay low until configuration is known, not only in
	// reset, so the mirror array and light sources see no glitch.
	always @(posedge ref_clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			illum_q   <= {4{`RSC_LOW_RST}};
			mrst_n_q  <= `RSC_LOW_RST;
			adc_clk_q <= `RSC_LOW_RST;
			adc_sdo_q <= `RSC_LOW_RST;
		end
		else
		begin
			illum_q   <= cfg_valid_q ? core_illum_sel_in : {4{`RSC_LOW_RST}};
			mrst_n_q  <= cfg_valid_q & core_mirror_rst_n_in;
			adc_clk_q <= cfg_valid_q & core_adc_clk_in;
			adc_sdo_q <= cfg_valid_q & core_adc_sdo_in;
		end
	end

	// General pads: value flops run freely, only the enable is gated
	always @(posedge ref_clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			gp_val_q <= {GP_W{`RSC_LOW_RST}};
			gp_oe_q  <= {GP_W{`RSC_OE_OFF}};
		end
		else
		begin
			gp_val_q <= core_gp_val_in;
			gp_oe_q  <= cfg_valid_q ? core_gp_oe_in : {GP_W{`RSC_OE_OFF}};
		end
	end

	// Strap pads: debug drive only once the capture is over, so an
	// early debug request cannot corrupt the latched straps
	always @(posedge ref_clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			strap_oe_q  <= {3{`RSC_OE_OFF}};
			strap_val_q <= {3{`RSC_LOW_RST}};
		end
		else
		begin
			strap_oe_q  <= cfg_valid_q ? dbg_strap_oe_in : {3{`RSC_OE_OFF}};
			strap_val_q <= dbg_strap_val_in;
		end
	end

	// ------------------------------------------------------------
	// Park request
	// ------------------------------------------------------------
	// Sampled on every edge, configured or not: a power loss may
	// come at any time, and reset leaves the mirrors parked.
	always @(posedge ref_clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			park_q <= `RSC_PARK_RST;
		else
			park_q <= (mirror_park_n_in == `RSC_PARK_ACTIVE);
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign host_if_strap_out            = strap_val_q[0];
	assign host_if_strap_oe_out         = strap_oe_q[0];
	assign spi_mode_strap_out           = strap_val_q[1];
	assign spi_mode_strap_oe_out        = strap_oe_q[1];
	assign integrity_code_select_out    = strap_val_q[2];
	assign integrity_code_select_oe_out = strap_oe_q[2];
	assign mirror_park_out              = park_q;
	assign illum_source_sel_0_out       = illum_q[0];
	assign illum_source_sel_1_out       = illum_q[1];
	assign illum_source_sel_2_out       = illum_q[2];
	assign illum_source_sel_3_out       = illum_q[3];
	assign mirror_array_reset_n_out     = mrst_n_q;
	assign monitor_adc_clk_out          = adc_clk_q;
	assign monitor_adc_sdo_out          = adc_sdo_q;
	assign gp_pad_out                   = gp_val_q;
	assign gp_pad_oe_out                = gp_oe_q;
	assign init_start_out               = init_start_q;
	assign config_valid_out             = cfg_valid_q;
	assign spi_cmd_en_out               = spi_cmd_q;
	assign i2c_cmd_en_out               = i2c_cmd_q;
	assign spi_diag_en_out              = spi_diag_q;
	assign i2c_diag_en_out              = i2c_diag_q;
	assign spi_mode_1_2_out             = spi_mode_q;
	assign cmd_use_checksum_out         = code_sel_q;

endmodule // rsc_top

`default_nettype wire

// ==== test/rsc_props.sv ====
/*
 * Checker for the reset and strap capture block, bound to rsc_top.
 * Assumes the bind hands on DELAY_CYC and GP_W of the instance.
 */
`timescale 1ns/1ps
`default_nettype none
module rsc_props
#(
	parameter int DELAY_CYC = 15,
	parameter int GP_W      = 8
)
(
	input wire logic            ref_clk_in,
	input wire logic            arst_n_in,
	input wire logic            host_if_strap_in,
	input wire logic            spi_mode_strap_in,
	input wire logic            integrity_code_select_in,
	input wire logic            mirror_park_n_in,
	input wire logic            host_if_strap_oe_out,
	input wire logic            spi_mode_strap_oe_out,
	input wire logic            integrity_code_select_oe_out,
	input wire logic            mirror_park_out,
	input wire logic            illum_source_sel_0_out,
	input wire logic            illum_source_sel_1_out,
	input wire logic            illum_source_sel_2_out,
	input wire logic            illum_source_sel_3_out,
	input wire logic            mirror_array_reset_n_out,
	input wire logic            monitor_adc_clk_out,
	input wire logic            monitor_adc_sdo_out,
	input wire logic [GP_W-1:0] gp_pad_oe_out,
	input wire logic            init_start_out,
	input wire logic            config_valid_out,
	input wire logic            spi_cmd_en_out,
	input wire logic            i2c_cmd_en_out,
	input wire logic            spi_diag_en_out,
	input wire logic            i2c_diag_en_out,
	input wire logic            spi_mode_1_2_out,
	input wire logic            cmd_use_checksum_out
);
	localparam int DM1 = DELAY_CYC - 1;
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (!arst_n_in);
	// ------------------------------------------------------------
	// Start-up sequence
	// ------------------------------------------------------------
	sequence s_cfg;
		##1 !init_start_out ##DM1 $rose(config_valid_out);
	endsequence
	AST_INIT_SEQ: assert property (init_start_out |-> s_cfg)
		else $error("init pulse not followed by capture on time");
	AST_STRAP_NO_DRIVE: assert property (!config_valid_out |-> !host_if_strap_oe_out
		&& !spi_mode_strap_oe_out && !integrity_code_select_oe_out)
		else $error("strap pad driven before capture");
	AST_SAFE_LOW: assert property (!config_valid_out |-> !(illum_source_sel_0_out
		|| illum_source_sel_1_out || illum_source_sel_2_out || illum_source_sel_3_out
		|| mirror_array_reset_n_out || monitor_adc_clk_out || monitor_adc_sdo_out))
		else $error("safe pad not low");
	AST_GP_TRI: assert property (!config_valid_out |-> gp_pad_oe_out == '0)
		else $error("pad driven before start-up");
	AST_HOST_SEL: assert property ($rose(config_valid_out) |->
		i2c_cmd_en_out == $past(host_if_strap_in) && spi_cmd_en_out != i2c_cmd_en_out)
		else $error("host port select wrong");
	AST_DIAG: assert property (config_valid_out |->
		spi_diag_en_out == i2c_cmd_en_out && i2c_diag_en_out == spi_cmd_en_out)
		else $error("diagnostic port wrong");
	AST_MODE_CODE: assert property ($rose(config_valid_out) |->
		spi_mode_1_2_out == $past(spi_mode_strap_in)
		&& cmd_use_checksum_out == $past(integrity_code_select_in))
		else $error("mode or integrity code wrong");
	AST_PARK: assert property ($past(arst_n_in) |->
		mirror_park_out == !$past(mirror_park_n_in))
		else $error("park output wrong");
	AST_HOLD: assert property (config_valid_out |=> config_valid_out
		&& $stable({i2c_cmd_en_out, spi_mode_1_2_out, cmd_use_checksum_out}))
		else $error("captured straps changed");
endmodule // rsc_props
`default_nettype wire

// ==== test/rsc_board.sv ====
/*
 * Board model: reset supervisor, power manager and strap resistors.
 * Assumes the bench paces it from the system clock.
 */
`timescale 1ns/1ps
`default_nettype none
module rsc_board
(
	input  wire logic       clk_in,
	input  wire logic       pwr_ok_in,
	input  wire logic       pwr_fail_in,
	input  wire logic [2:0] strap_res_in,
	input  wire logic [2:0] pad_oe_in,
	input  wire logic [2:0] pad_val_in,
	input  wire logic [6:0] safe_pad_in,
	output var  logic [6:0] safe_line_out,
	output var  logic       arst_n_out,
	output var  logic       park_n_out,
	output wire logic [2:0] pad_out
);
	// ------------------------------------------------------------
	// Supervisor and power manager
	// ------------------------------------------------------------
	initial
	begin
		arst_n_out = 1'h0;
		park_n_out = 1'h1;
	end
	always @(posedge clk_in)
	begin
		arst_n_out <= #1 pwr_ok_in; // Released only once supplies settle
		park_n_out <= #1 !pwr_fail_in; // Low ahead of power loss
	end
	// Undriven pad falls back to its strap resistor
	assign pad_out = (pad_oe_in & pad_val_in) | (~pad_oe_in & strap_res_in);
	// Seven safe lines: a pull-down holds each low unless the
	// controller really drives it high, as while power comes up
	always @*
		for (int j = 0; j < 7; j++)
			safe_line_out[j] = (safe_pad_in[j] === 1'h1);
endmodule // rsc_board
`default_nettype wire

// ==== test/rsc_top_test.sv ====
/*
 * Self-checking bench for rsc_top with board model and checker.
 * Assumes the design and its constants header are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
module rsc_top_test;
	localparam int DLY = 3;
	logic ref_clk_in, pwr_ok, pwr_fail, cfg_seen;
	logic [2:0] straps, dbg_strap_oe_in, dbg_strap_val_in, e;
	logic [3:0] core_illum_sel_in;
	logic core_mirror_rst_n_in, core_adc_clk_in, core_adc_sdo_in;
	logic [7:0] core_gp_val_in, core_gp_oe_in;
	logic [31:0] r;
	logic [2:0] exp_q[$];
	int n_fail, checks_done, cyc, i, k;
	wire arst_n_in, mirror_park_n_in, mirror_park_out, init_start_out, config_valid_out;
	wire [2:0] pad, so;
	wire host_if_strap_out, spi_mode_strap_out, integrity_code_select_out;
	wire host_if_strap_oe_out, spi_mode_strap_oe_out, integrity_code_select_oe_out;
	wire illum_source_sel_0_out, illum_source_sel_1_out, illum_source_sel_2_out;
	wire illum_source_sel_3_out, mirror_array_reset_n_out, monitor_adc_clk_out;
	wire monitor_adc_sdo_out, spi_cmd_en_out, i2c_cmd_en_out, spi_diag_en_out;
	wire i2c_diag_en_out, spi_mode_1_2_out, cmd_use_checksum_out;
	wire [7:0] gp_pad_out, gp_pad_oe_out;
	wire [6:0] safe_line;
	wire [6:0] safe = {illum_source_sel_3_out, illum_source_sel_2_out, illum_source_sel_1_out,
		illum_source_sel_0_out, mirror_array_reset_n_out, monitor_adc_clk_out, monitor_adc_sdo_out};
	wire [6:0] safe_exp = {core_illum_sel_in, core_mirror_rst_n_in, core_adc_clk_in, core_adc_sdo_in};
	wire host_if_strap_in = pad[0];
	wire spi_mode_strap_in = pad[1];
	wire integrity_code_select_in = pad[2];
	assign so = {integrity_code_select_oe_out, spi_mode_strap_oe_out, host_if_strap_oe_out};
	rsc_top #(.GP_W(8), .DELAY_CYC(DLY)) u_dut (.*);
	rsc_board u_board (.clk_in(ref_clk_in), .pwr_ok_in(pwr_ok), .pwr_fail_in(pwr_fail),
		.strap_res_in(straps), .pad_oe_in(so), .arst_n_out(arst_n_in),
		.pad_val_in({integrity_code_select_out, spi_mode_strap_out, host_if_strap_out}),
		.park_n_out(mirror_park_n_in), .pad_out(pad),
		.safe_pad_in(safe), .safe_line_out(safe_line));
	// ------------------------------------------------------------
	// Checking and closing
	// ------------------------------------------------------------
	task chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			n_fail++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task conclude;
		$display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial
	begin
		ref_clk_in = 1'h0;
		forever #50 ref_clk_in = ~ref_clk_in;
	end
	always @(posedge ref_clk_in)
	begin
		cyc++;
		if (cyc == 1000)
		begin
			n_fail++;
			conclude;
		end
	end
	// Scoreboard: oldest strap note against each fresh capture
	always @(posedge ref_clk_in)
		if (arst_n_in !== 1'h1)
			cfg_seen <= 1'h0;
		else if (config_valid_out === 1'h1 && !cfg_seen)
		begin
			cfg_seen <= 1'h1;
			e = exp_q.pop_front();
			chk({i2c_cmd_en_out, spi_mode_1_2_out, cmd_use_checksum_out}, e);
			chk({spi_cmd_en_out, spi_diag_en_out, i2c_diag_en_out}, {!e[2], e[2], !e[2]});
		end
	// ------------------------------------------------------------
	// Stimulus: every strap code, then disturbance after capture
	// ------------------------------------------------------------
	initial
	begin
		{pwr_ok, pwr_fail, straps, dbg_strap_oe_in, dbg_strap_val_in} = '0;
		{core_illum_sel_in, core_mirror_rst_n_in, core_adc_clk_in, core_adc_sdo_in} = '0;
		{core_gp_val_in, core_gp_oe_in} = '0;
		r = $urandom(32'h5535);
		#1 chk(safe_line, 8'h00);
		for (i = 0; i < 8; i++)
		begin
			@(posedge ref_clk_in);
			#1 pwr_ok = 1'h0;
			straps = i[2:0];
			repeat (2) @(posedge ref_clk_in);
			#1 r = $urandom;
			{core_illum_sel_in, core_mirror_rst_n_in, core_adc_clk_in} = r[5:0];
			{core_adc_sdo_in, core_gp_val_in, core_gp_oe_in, dbg_strap_val_in} = r[25:6];
			dbg_strap_oe_in = 3'h7;
			chk(safe, 8'h00);
			chk(safe_line, 8'h00);
			chk(gp_pad_oe_out, 8'h00);
			chk(so, 8'h00);
			exp_q.push_back({straps[0], straps[1], straps[2]});
			pwr_ok = 1'h1;
			for (k = 0; k < 30 && config_valid_out !== 1'h1; k++)
				@(posedge ref_clk_in);
			#1 straps = ~straps;
			pwr_fail = i[0];
			repeat (3) @(posedge ref_clk_in);
			#1 chk(mirror_park_out, i[0]);
			chk(so, 8'h07);
			chk({i2c_cmd_en_out, spi_mode_1_2_out, cmd_use_checksum_out}, {i[0], i[1], i[2]});
			chk(safe, safe_exp);
			chk(gp_pad_oe_out, core_gp_oe_in);
			chk(gp_pad_out, core_gp_val_in);
			chk(pad, dbg_strap_val_in);
		end
		conclude;
	end
endmodule // rsc_top_test
bind rsc_top rsc_props #(.DELAY_CYC(DELAY_CYC), .GP_W(GP_W)) u_props (.*);
`default_nettype wire
